// file: logic/ibr_pkg.sv
// shared constants and device register map for the bus recovery controller
package ibr_pkg;

    // device register indices on the device access port
    localparam logic [3:0] DEV_CR1  = 4'h0;
    localparam logic [3:0] DEV_CR2  = 4'h1;
    localparam logic [3:0] DEV_MR   = 4'h2;
    localparam logic [3:0] DEV_SR   = 4'h3;
    localparam logic [3:0] DEV_TDR  = 4'h4;
    localparam logic [3:0] DEV_PORT = 4'h5;

    // bus_control_one layout: enable, reception_disable, master, transmit, clock select
    localparam int CR1_ICE  = 7;
    localparam int CR1_RECEPTION_DISABLE = 6;
    localparam int CR1_MST  = 5;
    localparam int CR1_TRS  = 4;
    localparam logic [3:0] CKS_RECOVER = 4'h4;  // serial clock = peripheral clock / 84

    // control two: stop request and control logic reset
    localparam logic [7:0] CR2_STOP_REQ = 8'h40;
    localparam logic [7:0] CR2_CTL_RST  = 8'h02;

    // mode register: format_select (1 = clocked synchronous)
    localparam logic [7:0] MR_FS_SYNC = 8'h80;
    localparam logic [7:0] MR_FS_I2C  = 8'h00;

    // status flags, written with 0 to clear
    localparam int SR_TRANSMIT_DATA_EMPTY_FLAG  = 7;
    localparam int SR_TRANSMIT_END_FLAG  = 6;
    localparam int SR_RECEIVE_DATA_FULL_FLAG  = 5;
    localparam int SR_STOP  = 3;
    localparam int SR_AL    = 2;
    localparam int SR_ACKBR = 0;
    localparam logic [7:0] SR_ALL_ONE = 8'hFF;
    localparam logic [7:0] SR_ALL_CLR = 8'h00;

    // data_line_pin_level inside port_pin_data_register
    localparam int PORT_SDA = 7;

    // software register word addresses
    localparam logic [2:0] REG_CMD  = 3'h0;
    localparam logic [2:0] REG_TX   = 3'h1;
    localparam logic [2:0] REG_STAT = 3'h2;
    localparam logic [2:0] REG_IRQ  = 3'h3;
    localparam logic [2:0] REG_MASK = 3'h4;

    // command field codes and option bit
    localparam logic [1:0] CMD_SEND    = 2'h1;
    localparam logic [1:0] CMD_STOP    = 2'h2;
    localparam logic [1:0] CMD_RECOVER = 2'h3;
    localparam int CMD_RXEND = 2;

    // result codes, also the sticky interrupt bit numbers
    localparam logic [1:0] RES_OK    = 2'h0;
    localparam logic [1:0] RES_ACK   = 2'h1;
    localparam logic [1:0] RES_BUS   = 2'h2;
    localparam logic [1:0] RES_FATAL = 2'h3;
    localparam logic [3:0] MASK_RST  = 4'h0;

    // clock falls before a stop after receiving, one bit for recovery
    localparam logic [3:0] SCL_FALLS_STOP = 4'h9;
    localparam logic [3:0] SCL_FALLS_BIT  = 4'h1;

    // bounded poll time
    localparam int CLK_MHZ      = 100;
    localparam int POLL_TIME_US = 1000;
    localparam int POLL_CYC     = POLL_TIME_US * CLK_MHZ;

    // bus_control_one value with recovery clock select
    function automatic logic [7:0] cr1(input logic interface_enable, input logic reception_disable,
                                       input logic mst, input logic transmit_select);
        logic [7:0] v;
        v = {interface_enable, reception_disable, mst, transmit_select, CKS_RECOVER};
        return v;
    endfunction

endpackage

// file: logic/ibr_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module ibr_sync (
    input  wire logic clk_i,     // system clock
    input  wire logic resetn_i,  // async reset, active low
    input  wire logic pin_i,     // asynchronous pin
    output logic      level_o    // filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // level follows once stages two and three agree
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_reg  <= 1'b1;
            s2_reg  <= 1'b1;
            s3_reg  <= 1'b1;
            level_o <= 1'b1;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/ibr_host.sv
// controller driving the two-wire interface: byte send, stop, bus recovery
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ibr_host #(
    parameter int POLL_CYC = ibr_pkg::POLL_CYC  // bounded poll length in cycles
) (
    input  wire logic        clk_i,              // system clock, 100 MHz
    input  wire logic        resetn_i,           // async reset, active low
    input  wire logic [2:0]  avs_address_i,      // word address
    input  wire logic        avs_read_i,         // read request
    input  wire logic        avs_write_i,        // write request
    input  wire logic [31:0] avs_writedata_i,    // write data
    output logic [31:0]      avs_readdata_o,     // read data
    output logic             avs_waitrequest_o,  // stall
    output logic [3:0]       dev_addr_o,         // device register index
    output logic [7:0]       dev_wdata_o,        // device write data
    output logic             dev_write_o,        // device write request
    output logic             dev_read_o,         // device read request
    input  wire logic [7:0]  dev_rdata_i,        // device read data
    input  wire logic        dev_ack_i,          // device access done
    input  wire logic        scl_i,              // clock line pin level
    output logic             irq_o               // level interrupt
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE, S_TX_POLL, S_TX_WR, S_TX_WAIT,
        S_SP_CLR, S_SP_NINE, S_SP_ISSUE, S_SP_POLL, S_SP_SLV, S_SP_TRANSMIT_DATA_EMPTY_FLAG, S_SP_TRANSMIT_END_FLAG,
        S_RC_CR1, S_RC_RST, S_RC_CLR, S_RC_FS, S_RC_EN, S_RC_CLK, S_RC_BIT,
        S_RC_RECEPTION_DISABLE, S_RC_RECEIVE_DATA_FULL_FLAG, S_RC_PIN, S_RC_FS0, S_RC_SLV
    } ibr_state_e;

    ibr_state_e  state_reg;
    ibr_state_e  state_last_reg;
    logic        resp_reg;
    logic        avs_req;
    logic        fire;
    logic        cmd_go;
    logic [31:0] rd_mux;
    logic [7:0]  tx_reg;
    logic [1:0]  cmd_reg;
    logic        rx_end_reg;
    logic [1:0]  res_reg;
    logic        rec_ok_reg;
    logic [3:0]  irq_reg;
    logic [3:0]  mask_reg;
    logic [3:0]  irq_set;
    logic        acc_en;
    logic        acc_wr;
    logic [3:0]  acc_addr;
    logic [7:0]  acc_wdata;
    logic        acc_done_reg;
    logic [7:0]  rd_data_reg;
    logic [31:0] wait_cnt;
    logic        tmo;
    logic        scl_s;
    logic        scl_last_reg;
    logic [3:0]  fall_cnt;

    // ----------------------------------------------------------------
    // clock line sampling
    // ----------------------------------------------------------------
    ibr_sync u_scl (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    (scl_i),
        .level_o  (scl_s)
    );

    // count clock falls, restarted while idle and at clock start
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_last_reg <= 1'b1;
            fall_cnt     <= 4'h0;
        end else begin
            scl_last_reg <= scl_s;
            if (state_reg == S_IDLE || state_reg == S_RC_CLK) begin
                fall_cnt <= 4'h0;
            end else if (scl_last_reg && !scl_s && fall_cnt != 4'hF) begin
                fall_cnt <= fall_cnt + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // software register slave
    // ----------------------------------------------------------------
    // one wait cycle on every access
    assign avs_req           = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = avs_req & ~resp_reg;
    assign fire              = avs_req & resp_reg;
    assign cmd_go = fire && avs_write_i && avs_address_i == ibr_pkg::REG_CMD
                    && state_reg == S_IDLE && avs_writedata_i[1:0] != 2'h0;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            resp_reg <= 1'b0;
        end else begin
            resp_reg <= avs_req & ~resp_reg;
        end
    end

    // read back mux
    always_comb begin
        case (avs_address_i)
            ibr_pkg::REG_CMD:  rd_mux = {29'h0, rx_end_reg, cmd_reg};
            ibr_pkg::REG_TX:   rd_mux = {24'h0, tx_reg};
            ibr_pkg::REG_STAT: rd_mux = {25'h0, rd_data_reg[7:4], res_reg,
                                        state_reg != S_IDLE};
            ibr_pkg::REG_IRQ:  rd_mux = {28'h0, irq_reg};
            ibr_pkg::REG_MASK: rd_mux = {28'h0, mask_reg};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in the wait cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !resp_reg) begin
            avs_readdata_o <= rd_mux;
        end
    end

    // writable registers; transmit byte refused while busy
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_reg   <= 8'h00;
            mask_reg <= ibr_pkg::MASK_RST;
        end else if (fire && avs_write_i) begin
            if (avs_address_i == ibr_pkg::REG_TX && state_reg == S_IDLE) begin
                tx_reg <= avs_writedata_i[7:0];
            end
            if (avs_address_i == ibr_pkg::REG_MASK) begin
                mask_reg <= avs_writedata_i[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    // one sticky bit per result, set when a command ends
    assign irq_set = (state_last_reg != S_IDLE && state_reg == S_IDLE) ?
                     4'(4'h1 << res_reg) : 4'h0;

    // read clears only what was returned; a new set wins
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_reg <= 4'h0;
        end else if (fire && avs_read_i && avs_address_i == ibr_pkg::REG_IRQ) begin
            irq_reg <= (irq_reg & ~avs_readdata_o[3:0]) | irq_set;
        end else begin
            irq_reg <= irq_reg | irq_set;
        end
    end

    assign irq_o = |(irq_reg & mask_reg);

    // ----------------------------------------------------------------
    // device access per state
    // ----------------------------------------------------------------
    always_comb begin
        case (state_reg)
            S_TX_POLL, S_TX_WAIT, S_SP_POLL, S_SP_TRANSMIT_END_FLAG, S_RC_RECEIVE_DATA_FULL_FLAG: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b10, ibr_pkg::DEV_SR, 8'h00};
            end
            S_TX_WR: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_TDR, tx_reg};
            end
            S_SP_CLR: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_SR,
                    ibr_pkg::SR_ALL_ONE & ~(8'h01 << ibr_pkg::SR_TRANSMIT_END_FLAG)
                                        & ~(8'h01 << ibr_pkg::SR_STOP)};
            end
            S_SP_ISSUE: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_CR2,
                                                         ibr_pkg::CR2_STOP_REQ};
            end
            S_SP_SLV, S_RC_SLV: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_CR1,
                    ibr_pkg::cr1(1'b1, 1'b0, 1'b0, 1'b0)};
            end
            S_SP_TRANSMIT_DATA_EMPTY_FLAG: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_SR,
                    ibr_pkg::SR_ALL_ONE & ~(8'h01 << ibr_pkg::SR_TRANSMIT_DATA_EMPTY_FLAG)};
            end
            S_RC_CR1: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_CR1,
                    ibr_pkg::cr1(1'b0, 1'b0, 1'b0, 1'b0)};
            end
            S_RC_RST: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_CR2,
                                                         ibr_pkg::CR2_CTL_RST};
            end
            S_RC_CLR: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_SR,
                                                         ibr_pkg::SR_ALL_CLR};
            end
            S_RC_FS: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_MR,
                                                         ibr_pkg::MR_FS_SYNC};
            end
            S_RC_EN: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_CR1,
                    ibr_pkg::cr1(1'b1, 1'b0, 1'b0, 1'b0)};
            end
            S_RC_CLK: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_CR1,
                    ibr_pkg::cr1(1'b1, 1'b0, 1'b1, 1'b0)};
            end
            S_RC_RECEPTION_DISABLE: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_CR1,
                    ibr_pkg::cr1(1'b1, 1'b1, 1'b1, 1'b0)};
            end
            S_RC_PIN: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b10, ibr_pkg::DEV_PORT, 8'h00};
            end
            S_RC_FS0: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b11, ibr_pkg::DEV_MR,
                                                         ibr_pkg::MR_FS_I2C};
            end
            default: begin
                {acc_en, acc_wr, acc_addr, acc_wdata} = {2'b00, 4'h0, 8'h00};
            end
        endcase
    end

    // request held until acknowledged, done pulses one cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dev_read_o   <= 1'b0;
            dev_write_o  <= 1'b0;
            dev_addr_o   <= 4'h0;
            dev_wdata_o  <= 8'h00;
            acc_done_reg <= 1'b0;
            rd_data_reg  <= 8'h00;
        end else begin
            acc_done_reg <= 1'b0;
            if (dev_read_o || dev_write_o) begin
                if (dev_ack_i) begin
                    dev_read_o   <= 1'b0;
                    dev_write_o  <= 1'b0;
                    acc_done_reg <= 1'b1;
                    rd_data_reg  <= dev_rdata_i;
                end
            end else if (acc_en && !acc_done_reg) begin
                dev_read_o  <= ~acc_wr;
                dev_write_o <= acc_wr;
                dev_addr_o  <= acc_addr;
                dev_wdata_o <= acc_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // poll timer restarts on each state change
    assign tmo = wait_cnt >= 32'(POLL_CYC);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_last_reg <= S_IDLE;
            wait_cnt       <= 32'h0000_0000;
        end else begin
            state_last_reg <= state_reg;
            wait_cnt <= (state_reg != state_last_reg) ? 32'h0000_0000 : wait_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg  <= S_IDLE;
            cmd_reg    <= 2'h0;
            rx_end_reg <= 1'b0;
            res_reg    <= ibr_pkg::RES_OK;
            rec_ok_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: if (cmd_go) begin
                    cmd_reg    <= avs_writedata_i[1:0];
                    rx_end_reg <= avs_writedata_i[ibr_pkg::CMD_RXEND];
                    if (avs_writedata_i[1:0] == ibr_pkg::CMD_SEND) begin
                        state_reg <= S_TX_POLL;
                    end else if (avs_writedata_i[1:0] == ibr_pkg::CMD_STOP) begin
                        state_reg <= S_SP_CLR;
                    end else begin
                        state_reg <= S_RC_CR1;
                    end
                end
                S_TX_POLL: if (acc_done_reg) begin
                    if (rd_data_reg[ibr_pkg::SR_TRANSMIT_DATA_EMPTY_FLAG]) begin
                        state_reg <= S_TX_WR;
                    end else if (tmo) begin
                        res_reg   <= ibr_pkg::RES_BUS;
                        state_reg <= S_IDLE;
                    end
                end
                S_TX_WR: if (acc_done_reg) begin
                    state_reg <= S_TX_WAIT;
                end
                S_TX_WAIT: if (acc_done_reg) begin
                    if (rd_data_reg[ibr_pkg::SR_AL]) begin
                        res_reg   <= ibr_pkg::RES_BUS;
                        state_reg <= S_IDLE;
                    end else if (rd_data_reg[ibr_pkg::SR_TRANSMIT_END_FLAG]) begin
                        res_reg   <= rd_data_reg[ibr_pkg::SR_ACKBR] ?
                                     ibr_pkg::RES_ACK : ibr_pkg::RES_OK;
                        state_reg <= S_IDLE;
                    end else if (tmo) begin
                        res_reg   <= ibr_pkg::RES_BUS;
                        state_reg <= S_IDLE;
                    end
                end
                S_SP_CLR: if (acc_done_reg) begin
                    state_reg <= rx_end_reg ? S_SP_NINE : S_SP_ISSUE;
                end
                S_SP_NINE: begin
                    if (fall_cnt >= ibr_pkg::SCL_FALLS_STOP) begin
                        state_reg <= S_SP_ISSUE;
                    end else if (tmo) begin
                        res_reg   <= ibr_pkg::RES_BUS;
                        state_reg <= S_IDLE;
                    end
                end
                S_SP_ISSUE: if (acc_done_reg) begin
                    state_reg <= S_SP_POLL;
                end
                S_SP_POLL: if (acc_done_reg) begin
                    if (rd_data_reg[ibr_pkg::SR_STOP]) begin
                        state_reg <= S_SP_SLV;
                    end else if (tmo) begin
                        res_reg   <= ibr_pkg::RES_BUS;
                        state_reg <= S_IDLE;
                    end
                end
                S_SP_SLV: if (acc_done_reg) begin
                    state_reg <= S_SP_TRANSMIT_DATA_EMPTY_FLAG;
                end
                S_SP_TRANSMIT_DATA_EMPTY_FLAG: if (acc_done_reg) begin
                    state_reg <= S_SP_TRANSMIT_END_FLAG;
                end
                S_SP_TRANSMIT_END_FLAG: if (acc_done_reg) begin
                    if (rd_data_reg[ibr_pkg::SR_TRANSMIT_END_FLAG] || tmo) begin
                        res_reg   <= rd_data_reg[ibr_pkg::SR_TRANSMIT_END_FLAG] ?
                                     ibr_pkg::RES_OK : ibr_pkg::RES_BUS;
                        state_reg <= S_IDLE;
                    end
                end
                S_RC_CR1: if (acc_done_reg) begin
                    state_reg <= S_RC_RST;
                end
                S_RC_RST: if (acc_done_reg) begin
                    state_reg <= S_RC_CLR;
                end
                S_RC_CLR: if (acc_done_reg) begin
                    state_reg <= S_RC_FS;
                end
                S_RC_FS: if (acc_done_reg) begin
                    state_reg <= S_RC_EN;
                end
                S_RC_EN: if (acc_done_reg) begin
                    state_reg <= S_RC_CLK;
                end
                S_RC_CLK: if (acc_done_reg) begin
                    state_reg <= S_RC_BIT;
                end
                S_RC_BIT: begin
                    if (fall_cnt >= ibr_pkg::SCL_FALLS_BIT) begin
                        state_reg <= S_RC_RECEPTION_DISABLE;
                    end else if (tmo) begin
                        rec_ok_reg <= 1'b0;
                        state_reg  <= S_RC_FS0;
                    end
                end
                S_RC_RECEPTION_DISABLE: if (acc_done_reg) begin
                    state_reg <= S_RC_RECEIVE_DATA_FULL_FLAG;
                end
                S_RC_RECEIVE_DATA_FULL_FLAG: if (acc_done_reg) begin
                    if (rd_data_reg[ibr_pkg::SR_RECEIVE_DATA_FULL_FLAG]) begin
                        state_reg <= S_RC_PIN;
                    end else if (tmo) begin
                        rec_ok_reg <= 1'b0;
                        state_reg  <= S_RC_FS0;
                    end
                end
                S_RC_PIN: if (acc_done_reg) begin
                    rec_ok_reg <= rd_data_reg[ibr_pkg::PORT_SDA];
                    state_reg  <= S_RC_FS0;
                end
                S_RC_FS0: if (acc_done_reg) begin
                    state_reg <= S_RC_SLV;
                end
                S_RC_SLV: if (acc_done_reg) begin
                    res_reg   <= rec_ok_reg ? ibr_pkg::RES_OK : ibr_pkg::RES_FATAL;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: dv/ibr_host_properties.sv
// assertions on the controller ports
`timescale 1ns/10ps
`default_nettype none
module ibr_host_properties (
    input wire logic       clk_i, resetn_i, avs_read_i, avs_write_i, // clock, reset, requests
    input wire logic       avs_waitrequest_o, irq_o,                 // stall, interrupt
    input wire logic [3:0] dev_addr_o,                               // device index
    input wire logic [7:0] dev_wdata_o, dev_rdata_i,                 // device data
    input wire logic       dev_write_o, dev_read_o, dev_ack_i        // device handshake
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic       transmit_data_empty_flag_seen;
    logic [7:0] sr_w;
    wire logic  dack = dev_ack_i && (dev_read_o || dev_write_o);
    // remember last status read and last status write
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            transmit_data_empty_flag_seen <= 1'b0;
            sr_w      <= 8'hFF;
        end else if (dack && dev_addr_o == ibr_pkg::DEV_SR) begin
            if (dev_read_o) transmit_data_empty_flag_seen <= dev_rdata_i[ibr_pkg::SR_TRANSMIT_DATA_EMPTY_FLAG];
            if (dev_write_o) sr_w <= dev_wdata_o;
        end
    end
    wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o
        ##1 !avs_waitrequest_o) else $error("wait state wrong");
    req_excl_a: assert property (!(dev_read_o && dev_write_o)) else $error("read with write");
    req_hold_a: assert property ((dev_read_o || dev_write_o) && !dev_ack_i |=>
        $stable({dev_read_o, dev_write_o, dev_addr_o})) else $error("request dropped");
    data_hold_a: assert property (dev_write_o && !dev_ack_i |=> $stable(dev_wdata_o))
        else $error("write data moved");
    ack_drop_a: assert property (dack |=> !dev_read_o && !dev_write_o) else $error("no drop");
    tx_empty_a: assert property ($rose(dev_write_o) && dev_addr_o == ibr_pkg::DEV_TDR |->
        transmit_data_empty_flag_seen) else $error("byte before empty");
    stop_order_a: assert property ($rose(dev_write_o) && dev_addr_o == ibr_pkg::DEV_CR2 &&
        dev_wdata_o == ibr_pkg::CR2_STOP_REQ |-> !sr_w[ibr_pkg::SR_TRANSMIT_END_FLAG] && !sr_w[ibr_pkg::SR_STOP])
        else $error("stop before clear");
    clock_sel_a: assert property (dev_write_o && dev_addr_o == ibr_pkg::DEV_CR1 |->
        dev_wdata_o[3:0] == ibr_pkg::CKS_RECOVER) else $error("clock select");
    cover property ($rose(irq_o));
    cover property (dack && dev_addr_o == ibr_pkg::DEV_PORT);
    cover property ($rose(dev_write_o) && dev_addr_o == ibr_pkg::DEV_TDR);
endmodule
bind ibr_host ibr_host_properties u_props (.*);
`default_nettype wire

// file: dv/ibr_dev_model.sv
// behavioural two-wire interface device
`timescale 1ns/10ps
`default_nettype none
module ibr_dev_model (
    input wire logic       clk_i, resetn_i, wr_i, rd_i, // clock, reset, requests
    input wire logic [3:0] addr_i,                      // register index
    input wire logic [7:0] wdata_i,                     // write data
    input wire logic [2:0] fault_i,                     // 0 ack 1 nak 2 arb 3 stuck 4 dead
    output logic [7:0]     rdata_o, cr1_o, mr_o, tdr_o, // read data, written registers
    output logic           ack_o, scl_o                 // acknowledge, clock line
);
    logic [3:0] div, falls;
    wire logic  sda = fault_i < 3 || (fault_i == 3 && falls > 8);
    wire logic  tk = wr_i && ack_o;
    // status: arbitration loss, no stop while stuck, receive full after a frame
    wire logic [7:0] st = {2'b11, falls > 8, 1'b0, fault_i < 3, fault_i == 2, 1'b0,
        fault_i == 1};
    assign rdata_o = !rd_i ? ~st : addr_i == ibr_pkg::DEV_SR ? st : {sda, 7'h00};
    // writes, prompt acknowledge, clocks in synchronous format only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {ack_o, cr1_o, mr_o, tdr_o, div, falls} <= '0;
            scl_o <= 1'b1;
        end else begin
            ack_o <= (wr_i || rd_i) && !ack_o;
            if (tk && addr_i == ibr_pkg::DEV_CR1) cr1_o <= wdata_i;
            if (tk && addr_i == ibr_pkg::DEV_MR) mr_o <= wdata_i;
            if (tk && addr_i == ibr_pkg::DEV_TDR) tdr_o <= wdata_i;
            div <= (mr_o == ibr_pkg::MR_FS_SYNC && cr1_o[7] && cr1_o[5] &&
                !(cr1_o[6] && falls > 8)) ? div + 4'h1 : 4'h0;
            if (div == 4'h7) scl_o <= !scl_o;
            if (div == 4'h7 && scl_o && falls != 4'hF) falls <= falls + 4'h1;
            if (div == 4'h0) scl_o <= 1'b1;
            if (tk && addr_i == ibr_pkg::DEV_CR2) falls <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// file: dv/tb_ibr_host.sv
// testbench: byte send, stop and recovery against the device model
`timescale 1ns/10ps
`default_nettype none
module tb_ibr_host;
    logic        clk_i = 0, resetn_i = 0, rd = 0, wr = 0, ack, scl, dw, dr, wq, irq;
    logic [2:0]  adr = 0, fault = 0;
    logic [3:0]  da, msk = 0;
    logic [31:0] wd = 0, rdat, q;
    logic [7:0]  drd, dwd, cr1, mr, tdr;
    int          mismatches = 0, total_checks = 0;
    always #5 clk_i = ~clk_i;
    ibr_host #(.POLL_CYC(200)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .dev_addr_o(da), .dev_wdata_o(dwd), .dev_write_o(dw),
        .dev_read_o(dr), .dev_rdata_i(drd), .dev_ack_i(ack), .scl_i(scl), .irq_o(irq));
    ibr_dev_model u_dev (.clk_i(clk_i), .resetn_i(resetn_i), .wr_i(dw), .rd_i(dr), .addr_i(da),
        .wdata_i(dwd), .fault_i(fault), .rdata_o(drd), .cr1_o(cr1), .mr_o(mr), .tdr_o(tdr),
        .ack_o(ack), .scl_o(scl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic io(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {adr, wd, wr, rd} <= {a, d, w, !w};
        do @(posedge clk_i); while (wq !== 1'b0);
        q = rdat;
        {wr, rd} <= 2'b00;
    endtask
    task automatic run(input logic [2:0] f, input logic [2:0] c, input logic [1:0] res);
        fault <= f;
        io(1, ibr_pkg::REG_CMD, {29'h0, c});
        do io(0, ibr_pkg::REG_STAT, 0); while (q[0] !== 1'b0);
        chk(q[2:1], res);
        chk(irq, msk[res]);
        io(0, ibr_pkg::REG_IRQ, 0);
        chk(q[3:0], 4'h1 << res);
        @(posedge clk_i);
        chk(irq, 0);
    endtask
    task automatic test_done;
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial begin
        #200_000;
        mismatches++;
        test_done;
    end
    // sequences
    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1;
        io(0, ibr_pkg::REG_MASK, 0);
        chk(q, ibr_pkg::MASK_RST);
        io(0, 3'h7, 0);
        chk(q, 0);
        io(1, ibr_pkg::REG_TX, 32'h0000_00A5);
        run(0, ibr_pkg::CMD_SEND, ibr_pkg::RES_OK);
        chk(tdr, 8'hA5);
        run(2, ibr_pkg::CMD_SEND, ibr_pkg::RES_BUS);
        run(0, ibr_pkg::CMD_STOP, ibr_pkg::RES_OK);
        run(3, ibr_pkg::CMD_STOP, ibr_pkg::RES_BUS);
        run(3, ibr_pkg::CMD_RECOVER, ibr_pkg::RES_OK);
        chk({cr1, mr}, 16'h8400);
        run(4, ibr_pkg::CMD_RECOVER, ibr_pkg::RES_FATAL);
        run(0, {1'b1, ibr_pkg::CMD_STOP}, ibr_pkg::RES_BUS);
        msk = 4'h2;
        io(1, ibr_pkg::REG_MASK, {28'h0, msk});
        run(1, ibr_pkg::CMD_SEND, ibr_pkg::RES_ACK);
        test_done;
    end
endmodule
`default_nettype wire
